// file: common/crqg_pkg.sv
// Package with register map, field positions and reset values for the gate
`default_nettype none
package crqg_pkg;
  // Register byte offsets
  localparam logic [11:0] ADDR_EXT_ENABLE = 12'h000;
  localparam logic [11:0] ADDR_HS_MODE = 12'h004;
  localparam logic [11:0] ADDR_HOLD_ENABLE = 12'h008;
  localparam logic [11:0] ADDR_VARIANT = 12'h00c;
  localparam logic [11:0] ADDR_STATUS = 12'h010;
  localparam logic [11:0] ADDR_CONTROL = 12'h014;
  // Handshake mode encodings
  localparam logic [1:0] MODE_EMUL_ONLY = 2'h1;
  localparam logic [1:0] MODE_ALWAYS = 2'h2;
  // Probe variants
  localparam logic [1:0] VAR_FIRST = 2'h0;
  localparam logic [1:0] VAR_SECOND = 2'h1;
  localparam logic [1:0] VAR_THIRD = 2'h2;
  // Reset values
  localparam logic RST_EXT_ENABLE = 1'h0;
  localparam logic [1:0] RST_HS_MODE = 2'h1;
  localparam logic RST_HOLD_ENABLE = 1'h0;
  localparam logic [1:0] RST_VARIANT = 2'h0;
  // Control register bit positions
  localparam int CTL_FULL_RESET = 0;
  localparam int CTL_CPU_RESET = 1;
  // Status register bit positions
  localparam int ST_EMULATING = 0;
  localparam int ST_PENDING = 1;
  localparam int ST_DATA_REQ = 2;
  localparam int ST_HOLD_REQ = 3;
  localparam int ST_CPU_RESET = 4;
  // Pin synchroniser depth
  localparam int SYNC_DEPTH = 2;
endpackage
`default_nettype wire

// file: common/crqg_sync_if.sv
// Interface carrying raw pins into the synchroniser and synced levels out
`default_nettype none
interface crqg_sync_if;
  logic [3:0] raw;
  logic [3:0] synced;
  modport src (output raw, input synced);
  modport syn (input raw, output synced);
endinterface
`default_nettype wire

// file: verilog/crqg_sync.sv
// Two-stage synchroniser for asynchronous request pins
`default_nettype none
module crqg_sync (
  // Clock and reset
  input wire logic pclk,
  input wire logic presetn,
  input wire logic clk_en,
  // Pin bundle
  crqg_sync_if.syn sig
);
  logic [3:0] stage1_reg;
  logic [3:0] stage2_reg;

  // First stage feeds only the second stage
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      stage1_reg <= 4'h0;
      stage2_reg <= 4'h0;
    end else if (clk_en) begin
      stage1_reg <= sig.raw;
      stage2_reg <= stage1_reg;
    end
  end

  assign sig.synced = stage2_reg;
endmodule
`default_nettype wire

// file: verilog/crqg_top.sv
// Coprocessor request gating block with APB register slave
// Overview of operation
// RQ1: Enabled, mode 1: extension data request/ack honoured only while emulating.
// RQ2: Enabled, mode 2: extension lines honoured in emulation and interrogation.
// RQ3: Extension disabled: extension data request/ack never honoured.
// RQ4: Extension enable write uses only bit 0.
// RQ5: Disabled extension never receives an acknowledge; it waits forever.
// RQ6: Full emulator reset clears the extension enable.
// RQ7: Processor-only reset leaves the extension enable unchanged.
// RQ8: Bus-hold enable alone governs hold request/ack recognition. Code also needs the mode 1 emulation window and no first-variant strap.
// RQ9: First variant mode 1: grant or hold recognised only while emulating.
// RQ10: Mode 1: request outside emulation is latched, granted on entry.
// RQ11: Mode 2: coprocessor requests accepted at any time.
// RQ12: Mode 2: coprocessor memory cycles are never blocked.
// RQ13: Mode 2: coprocessor registers reachable by host while halted.
// RQ14: Handshake mode affects only the external coprocessor path.
// RQ15: Second variant mode 1: hold pair recognised only while emulating.
// RQ16: Host programs the handshake mode before emulation starts.
// RQ17: Mode 1 restart elsewhere: host resets coprocessor first.
// RQ18: Hang in mode 1: host resets coprocessor, then probe.
// RQ19: Handshake mode resets to 1.
`default_nettype none
module crqg_top (
  // Clock, reset, enable
  input wire logic pclk,
  input wire logic presetn,
  input wire logic clk_en,
  // APB slave
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [11:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  // Emulation state from probe control (same clock)
  input wire logic emulating,
  input wire logic int_coproc_req,
  // External coprocessor pins (asynchronous)
  input wire logic ext_data_request,
  input wire logic bus_hold_request,
  input wire logic request_grant_line,
  input wire logic max_config,
  // Gated outputs
  output logic ext_data_ack,
  output logic bus_hold_ack,
  output logic grant_pulse,
  output logic int_coproc_ack,
  output logic coproc_mem_allow,
  output logic coproc_reg_access,
  output logic cpu_reset_out
);
  // Settings registers
  logic ext_numeric_enable_reg;
  logic [1:0] coproc_handshake_mode_reg;
  logic bus_hold_enable_reg;
  logic [1:0] variant_reg;
  // Gating state
  logic pending_reg;
  logic ext_data_ack_reg;
  logic bus_hold_ack_reg;
  logic grant_pulse_reg;
  logic int_ack_reg;
  logic mem_allow_reg;
  logic reg_access_reg;
  logic cpu_reset_reg;
  logic [31:0] prdata_reg;
  logic pslverr_reg;
  logic grant_seen_reg;
  logic pready_reg;

  // Synchronised pins
  // Every pin from the coprocessor side is asynchronous to pclk, so all four
  // levels pass the two-stage synchroniser before any gating reads them.
  // The strap is synchronised too: it may be moved while the clock runs.
  // Cost: acknowledges appear three edges after a pin changes.
  crqg_sync_if pins ();
  assign pins.raw = {max_config, request_grant_line, bus_hold_request,
                     ext_data_request};
  crqg_sync u_sync (
    .pclk(pclk),
    .presetn(presetn),
    .clk_en(clk_en),
    .sig(pins)
  );
  wire data_req_s = pins.synced[0];
  wire hold_req_s = pins.synced[1];
  wire rqgt_s = pins.synced[2];
  wire max_cfg_s = pins.synced[3];

  // APB decode
  wire access = psel && penable && clk_en;
  wire wr_en = access && pwrite;
  wire hit_ext = (paddr == crqg_pkg::ADDR_EXT_ENABLE);
  wire hit_mode = (paddr == crqg_pkg::ADDR_HS_MODE);
  wire hit_hold = (paddr == crqg_pkg::ADDR_HOLD_ENABLE);
  wire hit_var = (paddr == crqg_pkg::ADDR_VARIANT);
  wire hit_stat = (paddr == crqg_pkg::ADDR_STATUS);
  wire hit_ctl = (paddr == crqg_pkg::ADDR_CONTROL);
  wire mapped = hit_ext | hit_mode | hit_hold | hit_var | hit_stat | hit_ctl;
  wire mode_ok = (pwdata[1:0] == crqg_pkg::MODE_EMUL_ONLY) ||
                 (pwdata[1:0] == crqg_pkg::MODE_ALWAYS);
  wire full_reset = wr_en && hit_ctl && pwdata[crqg_pkg::CTL_FULL_RESET];
  wire cpu_reset_cmd = wr_en && hit_ctl && pwdata[crqg_pkg::CTL_CPU_RESET];

  // Mode decode
  // The handshake window is open always in mode 2 and only while emulating
  // in mode 1. It gates the external lines only; the internal coprocessor
  // path never looks at it.
  // Mode changes during emulation are legal on the bus but not intended:
  // a change takes effect on the next edge, mid-transfer if need be.
  wire mode_always = (coproc_handshake_mode_reg == crqg_pkg::MODE_ALWAYS);
  wire open_window = mode_always || emulating; // RQ1 RQ2 RQ11
  wire ext_live = ext_numeric_enable_reg && open_window; // RQ3 RQ5
  wire hold_live = bus_hold_enable_reg && open_window; // RQ8 RQ9 RQ15
  wire is_first = (variant_reg == crqg_pkg::VAR_FIRST);
  wire rqgt_live = is_first && max_cfg_s && open_window; // RQ9
  wire hold_pin_live = hold_live && !(is_first && max_cfg_s);
  // Requests in mode 1 outside emulation are remembered
  wire any_req = (is_first && max_cfg_s) ? rqgt_s : hold_req_s;
  wire latch_req = !mode_always && !emulating && any_req &&
                   (bus_hold_enable_reg || (is_first && max_cfg_s));

  wire [31:0] status_word = {27'h0, cpu_reset_reg, hold_req_s, data_req_s,
                             pending_reg, emulating};
  wire [31:0] rd_mux =
    hit_ext ? {31'h0, ext_numeric_enable_reg} :
    hit_mode ? {30'h0, coproc_handshake_mode_reg} :
    hit_hold ? {31'h0, bus_hold_enable_reg} :
    hit_var ? {30'h0, variant_reg} :
    hit_stat ? status_word : 32'h0;

  // Settings: full reset clears all but the variant, processor reset does not
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      ext_numeric_enable_reg <= crqg_pkg::RST_EXT_ENABLE;
      coproc_handshake_mode_reg <= crqg_pkg::RST_HS_MODE; // RQ19
      bus_hold_enable_reg <= crqg_pkg::RST_HOLD_ENABLE;
      variant_reg <= crqg_pkg::RST_VARIANT;
    end else if (full_reset) begin
      ext_numeric_enable_reg <= crqg_pkg::RST_EXT_ENABLE; // RQ6
      coproc_handshake_mode_reg <= crqg_pkg::RST_HS_MODE; // RQ19
      bus_hold_enable_reg <= crqg_pkg::RST_HOLD_ENABLE;
    end else if (wr_en) begin
      if (hit_ext) begin
        ext_numeric_enable_reg <= pwdata[0]; // RQ4
      end
      if (hit_mode && mode_ok) begin
        coproc_handshake_mode_reg <= pwdata[1:0];
      end
      if (hit_hold) begin
        bus_hold_enable_reg <= pwdata[0];
      end
      if (hit_var) begin
        variant_reg <= pwdata[1:0];
      end
    end
  end

  // Processor reset pulse leaves settings alone
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      cpu_reset_reg <= 1'b0;
    end else if (clk_en) begin
      cpu_reset_reg <= cpu_reset_cmd; // RQ7
    end
  end

  // Pending request latch, granted on entry to emulation
  // A request seen outside emulation in mode 1 is held here until the next
  // entry into emulation, where it releases one grant or acknowledge.
  // The latch is cleared in the cycle that it is released, so a request
  // withdrawn in the meantime still gets its grant; software must reset the
  // coprocessor before restarting elsewhere to discard it.
  // A new request wins over a clear that falls in the same cycle, so a
  // request is never lost to a full reset; a change to mode 2 clears the latch.
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pending_reg <= 1'b0;
    end else if (clk_en) begin
      if (latch_req) begin
        pending_reg <= 1'b1; // RQ10
      end else if (full_reset || mode_always || emulating) begin
        pending_reg <= 1'b0;
      end
    end
  end

  // Acknowledge generation
  // Data acknowledge follows the synchronised request while the extension
  // is live; with the extension off no acknowledge ever comes, and the
  // requester waits with no timeout of its own.
  // The grant is a single-cycle pulse on a fresh request edge or on the
  // release of a pending request.
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      ext_data_ack_reg <= 1'b0;
      bus_hold_ack_reg <= 1'b0;
      grant_pulse_reg <= 1'b0;
      grant_seen_reg <= 1'b0;
    end else if (clk_en) begin
      ext_data_ack_reg <= ext_live && data_req_s; // RQ1 RQ2 RQ3 RQ5
      bus_hold_ack_reg <= hold_pin_live &&
                          (hold_req_s || (pending_reg && emulating)); // RQ8
      grant_seen_reg <= rqgt_s;
      grant_pulse_reg <= rqgt_live &&
                         ((rqgt_s && !grant_seen_reg) ||
                          (pending_reg && emulating)); // RQ9 RQ10
    end
  end

  // Internal path and mode 2 side effects
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      int_ack_reg <= 1'b0;
      mem_allow_reg <= 1'b0;
      reg_access_reg <= 1'b0;
    end else if (clk_en) begin
      int_ack_reg <= int_coproc_req; // RQ14
      mem_allow_reg <= mode_always || emulating; // RQ12
      reg_access_reg <= mode_always && !emulating; // RQ13
    end
  end

  // APB read data and error, registered in the setup phase, so no wait state
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      prdata_reg <= 32'h0;
      pslverr_reg <= 1'b0;
    end else if (clk_en) begin
      prdata_reg <= (psel && !penable && !pwrite) ? rd_mux : prdata_reg;
      pslverr_reg <= psel && !penable && !mapped;
    end
  end

  // Ready from a flop, high from the first enabled edge after reset
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pready_reg <= 1'b0;
    end else if (clk_en) begin
      pready_reg <= 1'b1;
    end
  end

  // Zero-wait ready once access phase starts
  assign pready = pready_reg;
  assign prdata = prdata_reg;
  assign pslverr = pslverr_reg;
  assign ext_data_ack = ext_data_ack_reg;
  assign bus_hold_ack = bus_hold_ack_reg;
  assign grant_pulse = grant_pulse_reg;
  assign int_coproc_ack = int_ack_reg;
  assign coproc_mem_allow = mem_allow_reg;
  assign coproc_reg_access = reg_access_reg;
  assign cpu_reset_out = cpu_reset_reg;
endmodule
`default_nettype wire

// file: tb/crqg_asserts.sv
// Port checks for the coprocessor request gate
`default_nettype none
module crqg_asserts (
  // Clock and reset
  input wire logic pclk,
  input wire logic presetn,
  // APB request side
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [11:0] paddr,
  input wire logic [31:0] pwdata,
  // Probe state and pins
  input wire logic emulating,
  input wire logic int_coproc_req,
  input wire logic int_coproc_ack,
  input wire logic ext_data_request,
  input wire logic ext_data_ack,
  input wire logic bus_hold_request,
  input wire logic bus_hold_ack,
  input wire logic coproc_mem_allow,
  input wire logic coproc_reg_access,
  input wire logic cpu_reset_out
);
  timeunit 1ns;
  timeprecision 100ps;
  default clocking @(posedge pclk); endclocking
  default disable iff (!presetn);
  logic acc, en_q;
  logic [1:0] md_q;
  // Completed bus write
  assign acc = psel && penable && pwrite;
  // Shadow of enable and mode, following bus writes
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      en_q <= 1'b0;
      md_q <= crqg_pkg::RST_HS_MODE;
    end else if (acc && paddr == crqg_pkg::ADDR_CONTROL && pwdata[0]) begin
      en_q <= 1'b0;
      md_q <= crqg_pkg::RST_HS_MODE;
    end else if (acc && paddr == crqg_pkg::ADDR_EXT_ENABLE) begin
      en_q <= pwdata[0];
    end else if (acc && paddr == crqg_pkg::ADDR_HS_MODE && pwdata < 32'h3
                 && pwdata != 32'h0) begin
      md_q <= pwdata[1:0];
    end
  end
  chk_disabled_no_ack: assert property (!en_q && !$past(en_q)
    |-> !ext_data_ack) else $error("ack while extension disabled");
  chk_data_ack_cause: assert property (ext_data_ack |->
    $past(ext_data_request, 3)) else $error("ack without request");
  chk_mode1_emul_only: assert property (
    $past(md_q) == crqg_pkg::MODE_EMUL_ONLY && !emulating &&
    !$past(emulating) && !$past(emulating, 2) |-> !ext_data_ack)
    else $error("mode 1 ack outside emulation");
  chk_hold_ack_cause: assert property (bus_hold_ack |->
    $past(bus_hold_request, 3) || ($past(emulating) &&
    !$past(emulating, 2))) else $error("hold ack without request");
  chk_int_ack_follow: assert property ($past(presetn) |->
    int_coproc_ack == $past(int_coproc_req)) else $error("int ack lag");
  chk_reg_access_halt: assert property (coproc_reg_access |->
    $past(md_q) == crqg_pkg::MODE_ALWAYS && !$past(emulating))
    else $error("register access outside mode 2 halt");
  chk_mem_allow_emul: assert property ($past(presetn) &&
    $past(emulating) |-> coproc_mem_allow) else $error("memory blocked");
  chk_cpu_reset_pulse: assert property (acc && pwdata[1] &&
    paddr == crqg_pkg::ADDR_CONTROL |=> cpu_reset_out ##1 !cpu_reset_out)
    else $error("processor reset pulse wrong");
  cover property (ext_data_ack);
  cover property (bus_hold_ack);
  cover property (cpu_reset_out);
endmodule
`default_nettype wire

// file: tb/crqg_cop_model.sv
// Behavioural external coprocessor driving the request pins
`default_nettype none
module crqg_cop_model (
  // Bench commands
  input wire logic want_data,
  input wire logic want_hold,
  input wire logic want_grant,
  // Request pins
  output logic ext_data_request,
  output logic bus_hold_request,
  output logic request_grant_line
);
  timeunit 1ns;
  timeprecision 100ps;
  // Requests stay up as levels until the bench withdraws them
  assign ext_data_request = want_data;
  assign bus_hold_request = want_hold;
  assign request_grant_line = want_grant;
endmodule
`default_nettype wire

// file: tb/test_coproc_request_gating.sv
// Self-checking bench for the coprocessor request gate
`default_nettype none
module test_coproc_request_gating;
  timeunit 1ns;
  timeprecision 100ps;
  logic pclk, presetn = 1'b0, clk_en = 1'b1, max_config = 1'b0;
  logic psel = 1'b0, penable = 1'b0, pwrite = 1'b0, pready, pslverr;
  logic [11:0] paddr = 12'h000;
  logic [31:0] pwdata = 32'h0, prdata, q;
  logic emulating = 1'b0, int_coproc_req = 1'b0, err, g;
  logic want_data = 1'b0, want_hold = 1'b0, want_grant = 1'b0;
  logic ext_data_request, bus_hold_request, request_grant_line;
  logic ext_data_ack, bus_hold_ack, grant_pulse, int_coproc_ack;
  logic coproc_mem_allow, coproc_reg_access, cpu_reset_out;
  int failures = 0, total_checks = 0;
  crqg_top crqg_top_i (.*);
  crqg_cop_model crqg_cop_model_i (.*);
  // 200 MHz clock
  initial begin
    pclk = 1'b0;
    forever #2.5 pclk = ~pclk;
  end
  task automatic chk(input string s, input logic [31:0] e, gv);
    total_checks++;
    if (gv !== e) begin
      failures++;
      $display("unexpected %s: expected %h seen %h", s, e, gv);
    end
  endtask
  // APB transfer held until pready is sampled high
  task automatic apb(input logic w, input logic [11:0] a,
                     input logic [31:0] d);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    do @(posedge pclk); while (pready !== 1'b1);
    q = prdata;
    err = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
    @(posedge pclk);
  endtask
  task automatic w6();
    repeat (6) @(posedge pclk);
  endtask
  task automatic t_reset();
    apb(1'b0, crqg_pkg::ADDR_EXT_ENABLE, 32'h0);
    chk("enable", 32'h0, q);
    apb(1'b0, crqg_pkg::ADDR_HS_MODE, 32'h0);
    chk("mode", 32'h1, q);
    apb(1'b0, 12'h020, 32'h0);
    chk("slverr", 32'h1, err);
    $display("reset done");
  endtask
  task automatic t_bit0();
    apb(1'b1, crqg_pkg::ADDR_EXT_ENABLE, 32'hffff_fffe);
    apb(1'b0, crqg_pkg::ADDR_EXT_ENABLE, 32'h0);
    chk("enable", 32'h0, q);
    apb(1'b1, crqg_pkg::ADDR_EXT_ENABLE, 32'h3);
    apb(1'b0, crqg_pkg::ADDR_EXT_ENABLE, 32'h0);
    chk("enable", 32'h1, q);
    $display("bit0 done");
  endtask
  task automatic t_mode1();
    want_data <= 1'b1;
    int_coproc_req <= 1'b1;
    w6();
    chk("data ack", 32'h0, ext_data_ack);
    chk("int ack", 32'h1, int_coproc_ack);
    emulating <= 1'b1;
    w6();
    chk("data ack", 32'h1, ext_data_ack);
    want_data <= 1'b0;
    int_coproc_req <= 1'b0;
    emulating <= 1'b0;
    w6();
    $display("mode1 done");
  endtask
  task automatic t_mode2();
    apb(1'b1, crqg_pkg::ADDR_HS_MODE, 32'h2);
    want_data <= 1'b1;
    w6();
    chk("data ack", 32'h1, ext_data_ack);
    chk("reg access", 32'h1, coproc_reg_access);
    chk("mem allow", 32'h1, coproc_mem_allow);
    want_data <= 1'b0;
    w6();
    $display("mode2 done");
  endtask
  task automatic t_disabled();
    apb(1'b1, crqg_pkg::ADDR_EXT_ENABLE, 32'h0);
    want_data <= 1'b1;
    emulating <= 1'b1;
    w6();
    chk("data ack", 32'h0, ext_data_ack);
    w6();
    chk("data ack", 32'h0, ext_data_ack);
    want_data <= 1'b0;
    emulating <= 1'b0;
    $display("disabled done");
  endtask
  task automatic t_hold();
    apb(1'b1, crqg_pkg::ADDR_HS_MODE, 32'h1);
    apb(1'b1, crqg_pkg::ADDR_HOLD_ENABLE, 32'h1);
    want_hold <= 1'b1;
    w6();
    chk("hold ack", 32'h0, bus_hold_ack);
    want_hold <= 1'b0;
    w6();
    emulating <= 1'b1;
    g = 1'b0;
    repeat (6) begin
      @(posedge pclk);
      g = g | bus_hold_ack;
    end
    chk("held ack", 32'h1, g);
    want_hold <= 1'b1;
    w6();
    chk("hold ack", 32'h1, bus_hold_ack);
    want_hold <= 1'b0;
    emulating <= 1'b0;
    w6();
    $display("hold done");
  endtask
  task automatic t_grant();
    max_config <= 1'b1;
    want_grant <= 1'b1;
    w6();
    chk("grant", 32'h0, grant_pulse);
    want_grant <= 1'b0;
    emulating <= 1'b1;
    g = 1'b0;
    repeat (6) begin
      @(posedge pclk);
      g = g | grant_pulse;
    end
    chk("grant", 32'h1, g);
    max_config <= 1'b0;
    emulating <= 1'b0;
    w6();
    $display("grant done");
  endtask
  task automatic t_cpu();
    apb(1'b1, crqg_pkg::ADDR_EXT_ENABLE, 32'h1);
    apb(1'b1, crqg_pkg::ADDR_CONTROL, 32'h2);
    apb(1'b0, crqg_pkg::ADDR_EXT_ENABLE, 32'h0);
    chk("enable", 32'h1, q);
    apb(1'b1, crqg_pkg::ADDR_CONTROL, 32'h1);
    apb(1'b0, crqg_pkg::ADDR_EXT_ENABLE, 32'h0);
    chk("enable", 32'h0, q);
    $display("cpu reset done");
  endtask
  task automatic final_report();
    $display("checks %0d failures %0d", total_checks, failures);
    if (failures == 0 && total_checks > 0) begin
      $display("== PASSED ==");
    end else begin
      $display("== FAILED ==");
    end
    $finish;
  endtask
  // Main sequence
  initial begin
    repeat (3) @(posedge pclk);
    presetn <= 1'b1;
    @(posedge pclk);
    t_reset();
    t_bit0();
    t_mode1();
    t_mode2();
    t_disabled();
    t_hold();
    t_grant();
    t_cpu();
    final_report();
  end
  // Watchdog against a hung handshake
  initial begin
    repeat (5000) @(posedge pclk);
    failures++;
    final_report();
  end
endmodule
bind crqg_top crqg_asserts crqg_asserts_i (.*);
`default_nettype wire
